//--- rtl/spc_regs.svh
// Constants of the status protection and configuration block: bit positions, reset values, opcodes.
// Assumes a command decoder in front of it that hands over decoded command strobes and data bytes.
// Contract
// - Invert bit flips array protection; default 0
// - Two guard bits are non-volatile read/write
// - Guards 00: pin ignored, latch required
// - Guards 01, pin low: writes rejected
// - Guards 01, pin high: latch allows writes
// - Guards 10: locked until power cycle or soft reset
// - Guards 10 cleared by power/software reset
// - Guards 11: status permanently write protected
// - Busy, latch, suspend unaffected by writes
// - Ordinary enable then write: non-volatile copies
// - Volatile enable then write: volatile copies
// - Lock bits have no volatile copy
// - Suspend sets flag; resume/power clears
// - Lock bits one-time settable, never cleared
// - Lock bit zero factory set to one
// - Quad enable turns guard/pause pins into data
// - Shared pin: pause or reset by function bit
// - Drive level decode 50/25/75/100 percent
// - Fast mode bit enables high-frequency mode
// - Latency code selects 1-15 dummy cycles
// - Plain read never uses dummy cycles
// - Legacy dummy and mode counts per read
// - Program/erase into protected range ignored
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
`define SPC_OP_WREN       8'h06
`define SPC_OP_WREN_VOL   8'h50
`define SPC_OP_SUSPEND    8'h75
`define SPC_OP_RESUME     8'h7A
// Status register one fields
`define SPC_S1_BUSY       0
`define SPC_S1_WEL        1
`define SPC_S1_GLOW       7
// Status register two fields
`define SPC_S2_GHIGH      0
`define SPC_S2_QUAD       1
`define SPC_S2_LB0        2
`define SPC_S2_INV        6
`define SPC_S2_SUS        7
// Status register three fields
`define SPC_S3_PINF       7
`define SPC_S3_FAST       4
// Reset / delivery values of the stored images, then legacy mode and dummy counts of the reads
`define SPC_S1_RST        8'h00
`define SPC_S2_RST        8'h04
`define SPC_S3_RST        8'h40
`define SPC_LEGACY_DUMMY  4'h8
`define SPC_DIO_MODE      4'h4
`define SPC_DIO_DUMMY     4'h0
`define SPC_QIO_MODE      4'h2
`define SPC_QIO_DUMMY     4'h4
`define SPC_WQIO_DUMMY    4'h2
`endif

//--- rtl/spc_pkg.sv
// Types of the status protection and configuration block.
// Shared by the block and the bench; holds no constants of its own.
package spc_pkg;
  // Read command kinds handed in by the decoder
  typedef enum logic [2:0] {
    SPC_RD_PLAIN = 3'h0,
    SPC_RD_FAST  = 3'h1,
    SPC_RD_DOUT  = 3'h2,
    SPC_RD_QOUT  = 3'h3,
    SPC_RD_DIO   = 3'h4,
    SPC_RD_QIO   = 3'h5,
    SPC_RD_WQIO  = 3'h6
  } spc_rdkind_e;
  // Which copy the next status write targets
  typedef enum logic [1:0] {
    SPC_WT_NONE = 2'b00,
    SPC_WT_NV   = 2'b01,
    SPC_WT_VOL  = 2'b11
  } spc_wtarget_e;
  typedef logic [7:0] spc_byte_t;
endpackage

//--- rtl/spc_status_protect.sv
// Status register protection and configuration for a serial flash.
// Assumes a command decoder on clk_sys giving one-cycle opcode and write strobes; pins already synchronised
// there would be harmless, but the two pins here still pass two flops.
`timescale 1ns/1ps
`include "spc_regs.svh"
module spc_status_protect (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                power_up,
  input  wire logic                soft_reset,
  input  wire logic                cmd_valid,
  input  wire logic [7:0]          cmd_opcode,
  input  wire logic                wrsr_valid,
  input  wire logic [7:0]          wrsr_s1,
  input  wire logic [7:0]          wrsr_s2,
  input  wire logic [7:0]          wrsr_s3,
  input  wire logic [1:0]          wrsr_mask,
  input  wire logic                wel_clear,
  input  wire logic                busy_in,
  input  wire logic                guard_pin_n,
  input  wire logic                shared_pin_n,
  input  wire logic [5:0]          pe_block_lo,
  input  wire logic [5:0]          pe_block_hi,
  input  wire logic                pe_check,
  input  wire spc_pkg::spc_rdkind_e rd_kind,
  output logic [7:0]               status_reg_one,
  output logic [7:0]               status_reg_two,
  output logic [7:0]               status_reg_three,
  output logic                     wrsr_accepted,
  output logic                     wrsr_rejected,
  output logic                     pe_allowed,
  output logic                     quad_pins_data,
  output logic                     pause_active,
  output logic                     pin_reset_active,
  output logic                     pin_write_guard_low,
  output logic [1:0]               drive_level,
  output logic [6:0]               drive_percent,
  output logic                     fast_mode_bit,
  output logic [3:0]               rd_mode_cycles,
  output logic [3:0]               rd_dummy_cycles,
  output logic [2:0]               security_locked_n
);
  // Non-volatile images and volatile working copies
  logic [7:0] nv1_q, nv2_q, nv3_q;
  logic [7:0] v1_q, v2_q, v3_q;
  logic       wel_q, sus_q, loaded_q;
  spc_pkg::spc_wtarget_e tgt_q;
  logic [1:0] gp_meta_q, gp_q;

  // Two-flop synchronisers for the pins
  always_ff @(posedge clk_sys) begin
    gp_meta_q <= {guard_pin_n, shared_pin_n};
    gp_q      <= gp_meta_q;
  end
  wire guard_pin_hi  = gp_q[1];
  wire shared_pin_hi = gp_q[0];

  // Protection decision over the working guard bits
  wire g_hi = v2_q[`SPC_S2_GHIGH];
  wire g_lo = v1_q[`SPC_S1_GLOW];
  wire quad = v2_q[`SPC_S2_QUAD];
  // Pin function only counts while quad is off
  wire pin_ok = quad | guard_pin_hi;
  wire guards_allow = (!g_hi && !g_lo) ||
                      (!g_hi && g_lo && pin_ok);
  // Patterns 10 and 11 never allow
  wire wr_ok = wrsr_valid && wel_q && guards_allow && (tgt_q != spc_pkg::SPC_WT_NONE);
  wire is_nv  = (tgt_q == spc_pkg::SPC_WT_NV);
  wire is_vol = (tgt_q == spc_pkg::SPC_WT_VOL);

  // Writable masks: busy, latch and suspend never written
  wire [7:0] m1 = 8'hFC;
  // Lock bits: OR-only in the non-volatile copy, absent in volatile
  wire [7:0] lk_new = nv2_q | (wrsr_s2 & 8'h38);
  wire [7:0] nv2_w = {nv2_q[7], wrsr_s2[6], lk_new[5:3], 1'b1, wrsr_s2[1:0]};
  wire [7:0] v2_w  = {v2_q[7], wrsr_s2[6], v2_q[5:2], wrsr_s2[1:0]};
  // Drive level has no non-volatile copy; keep stored image bits
  wire [7:0] nv3_w = {wrsr_s3[7], nv3_q[6:5], wrsr_s3[4:0]};
  wire do_s12 = wr_ok && wrsr_mask[0];
  wire do_s3  = wr_ok && wrsr_mask[1];
  wire lockdown = g_hi && !g_lo;

  // Reset images, non-volatile writes, and lock-down release on power-up or soft reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nv1_q    <= `SPC_S1_RST;
      nv2_q    <= `SPC_S2_RST;
      nv3_q    <= `SPC_S3_RST;
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      if (do_s12 && is_nv) begin
        nv1_q <= (nv1_q & ~m1) | (wrsr_s1 & m1);
        nv2_q <= nv2_w;
      end
      if (do_s3 && is_nv) begin
        nv3_q <= nv3_w;
      end
      if ((power_up || soft_reset) && lockdown) begin
        nv1_q[`SPC_S1_GLOW]  <= 1'b0;
        nv2_q[`SPC_S2_GHIGH] <= 1'b0;
      end
    end
  end

  // Working copies steer the device
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      v1_q <= 8'h00;
      v2_q <= 8'h00;
      v3_q <= 8'h00;
    end else if (!loaded_q || power_up || soft_reset) begin
      v1_q <= lockdown ? (nv1_q & 8'h7F) : nv1_q;
      v2_q <= lockdown ? (nv2_q & 8'hFE) : nv2_q;
      v3_q <= nv3_q;
    end else begin
      if (do_s12) begin
        v1_q <= (v1_q & ~m1) | (wrsr_s1 & m1);
        v2_q <= is_vol ? v2_w : nv2_w;
      end
      if (do_s3) begin
        v3_q <= wrsr_s3;
      end
    end
  end

  // Write latch, write target and suspend flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wel_q <= 1'b0;
      tgt_q <= spc_pkg::SPC_WT_NONE;
      sus_q <= 1'b0;
    end else begin
      if (wrsr_valid || wel_clear || power_up || soft_reset) begin
        wel_q <= 1'b0;
        tgt_q <= spc_pkg::SPC_WT_NONE;
      end
      if (cmd_valid && cmd_opcode == `SPC_OP_WREN) begin
        wel_q <= 1'b1;
        tgt_q <= spc_pkg::SPC_WT_NV;
      end
      if (cmd_valid && cmd_opcode == `SPC_OP_WREN_VOL) begin
        tgt_q <= spc_pkg::SPC_WT_VOL;           // Volatile enable also sets the latch bit
        wel_q <= 1'b1;
      end
      if (power_up || (cmd_valid && cmd_opcode == `SPC_OP_RESUME)) begin
        sus_q <= 1'b0;
      end else if (cmd_valid && cmd_opcode == `SPC_OP_SUSPEND) begin
        sus_q <= 1'b1;
      end
    end
  end

  // Block protection over 64 kB blocks, inverted by the invert bit
  function automatic logic [31:0] prot_map(input logic [4:0] f);
    logic [5:0] n;
    n = 6'h00;
    if (f[2:1] == 2'b11)
      n = 6'd32;
    else if (!f[4] && f[2:0] != 3'b000)
      n = 6'(6'd1 << (f[2:0] - 3'd1));
    else if (f[4] && f[2:0] != 3'b000)
      n = 6'd1;                                  // sector grain still touches one block
    prot_map = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (f[3] ? (i < n) : (i >= 32 - n))
        prot_map[i] = 1'b1;
    end
  endfunction
  wire [31:0] base_map = prot_map(v1_q[6:2]);
  wire [31:0] eff_map  = v2_q[`SPC_S2_INV] ? ~base_map : base_map;
  logic [31:0] range_map;
  always_comb begin
    range_map = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (6'(i) >= pe_block_lo && 6'(i) <= pe_block_hi)
        range_map[i] = 1'b1;
    end
  end
  wire pe_ok = pe_check && ((eff_map & range_map) == 32'h0000_0000);

  // Read timing decode
  logic [3:0] mode_d, dummy_d;
  wire [3:0] lc = v3_q[3:0];
  always_comb begin
    mode_d  = 4'h0;
    dummy_d = 4'h0;
    case (rd_kind)
      spc_pkg::SPC_RD_PLAIN: dummy_d = 4'h0;
      spc_pkg::SPC_RD_FAST, spc_pkg::SPC_RD_DOUT, spc_pkg::SPC_RD_QOUT:
        dummy_d = (lc == 4'h0) ? `SPC_LEGACY_DUMMY : lc;
      spc_pkg::SPC_RD_DIO: begin
        mode_d  = `SPC_DIO_MODE;
        dummy_d = (lc == 4'h0) ? `SPC_DIO_DUMMY : lc;
      end
      spc_pkg::SPC_RD_QIO: begin
        mode_d  = `SPC_QIO_MODE;
        dummy_d = (lc == 4'h0) ? `SPC_QIO_DUMMY : lc;
      end
      spc_pkg::SPC_RD_WQIO: begin
        mode_d  = `SPC_QIO_MODE;
        dummy_d = (lc == 4'h0) ? `SPC_WQIO_DUMMY : lc;
      end
      default: dummy_d = 4'h0;
    endcase
  end

  // Drive strength decode
  logic [6:0] pct_d;
  always_comb begin
    case (v3_q[6:5])
      2'b00:   pct_d = 7'd50;
      2'b01:   pct_d = 7'd25;
      2'b10:   pct_d = 7'd75;
      default: pct_d = 7'd100;
    endcase
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_reg_one      <= 8'h00;
      status_reg_two      <= 8'h00;
      status_reg_three    <= 8'h00;
      wrsr_accepted       <= 1'b0;
      wrsr_rejected       <= 1'b0;
      pe_allowed          <= 1'b0;
      quad_pins_data      <= 1'b0;
      pause_active        <= 1'b0;
      pin_reset_active    <= 1'b0;
      pin_write_guard_low <= 1'b0;
      drive_level         <= 2'b00;
      drive_percent       <= 7'd0;
      fast_mode_bit       <= 1'b0;
      rd_mode_cycles      <= 4'h0;
      rd_dummy_cycles     <= 4'h0;
      security_locked_n   <= 3'b111;
    end else begin
      status_reg_one   <= {v1_q[7:2], wel_q, busy_in};
      status_reg_two   <= {sus_q, v2_q[6], nv2_q[5:2], v2_q[1:0]};
      status_reg_three <= v3_q;
      wrsr_accepted    <= wr_ok;
      wrsr_rejected    <= wrsr_valid && !wr_ok;
      pe_allowed       <= pe_ok;
      quad_pins_data   <= quad;
      pause_active     <= !quad && !v3_q[`SPC_S3_PINF] && !shared_pin_hi;
      pin_reset_active <= !quad && v3_q[`SPC_S3_PINF] && !shared_pin_hi;
      pin_write_guard_low <= !quad && !guard_pin_hi;
      drive_level      <= v3_q[6:5];
      drive_percent    <= pct_d;
      fast_mode_bit    <= v3_q[`SPC_S3_FAST];
      rd_mode_cycles   <= mode_d;
      rd_dummy_cycles  <= dummy_d;
      security_locked_n <= ~nv2_q[5:3];
    end
  end
endmodule

//--- tb/spc_status_protect_assertions.sv
// Checker for the status protection block, fed only from the block's ports.
// Assumes images are valid from the third edge after reset is released.
`timescale 1ns/1ps
module spc_sp_checker (
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic                 wrsr_valid,
  input wire spc_pkg::spc_rdkind_e rd_kind,
  input wire logic [7:0]           status_reg_one,
  input wire logic [7:0]           status_reg_two,
  input wire logic                 wrsr_accepted,
  input wire logic                 wrsr_rejected,
  input wire logic                 quad_pins_data,
  input wire logic                 pause_active,
  input wire logic                 pin_reset_active,
  input wire logic                 pin_write_guard_low,
  input wire logic [1:0]           drive_level,
  input wire logic [6:0]           drive_percent,
  input wire logic [3:0]           rd_dummy_cycles
);
  logic [1:0] up_q;
  logic [1:0] up_d;
  logic [6:0] pct_w;
  logic       g_hi;
  logic       g_lo;
  // Edges since reset; images from before reset must not be compared
  assign up_d  = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  assign g_hi  = status_reg_two[0];
  assign g_lo  = status_reg_one[7];
  assign pct_w = drive_level[1] ? (drive_level[0] ? 7'h64 : 7'h4B) : (drive_level[0] ? 7'h19 : 7'h32);
  always_ff @(posedge clk_sys) begin
    if (reset) up_q <= 2'h0;
    else up_q <= up_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_one_answer; wrsr_valid |=> (wrsr_accepted != wrsr_rejected); endproperty
  a_one_answer: assert property (p_one_answer) else $error("status write got no single verdict");
  property p_answer_cause; (wrsr_accepted | wrsr_rejected) |-> $past(wrsr_valid); endproperty
  a_answer_cause: assert property (p_answer_cause) else $error("verdict without a write");
  property p_lockdown; (g_hi & ~g_lo & wrsr_valid) |=> wrsr_rejected; endproperty
  a_lockdown: assert property (p_lockdown) else $error("write taken in lock-down");
  property p_otp; (g_hi & g_lo & wrsr_valid) |=> wrsr_rejected; endproperty
  a_otp: assert property (p_otp) else $error("write taken in permanent lock");
  property p_hw_guard; (~g_hi & g_lo & pin_write_guard_low & ~quad_pins_data & wrsr_valid) |=> wrsr_rejected;
  endproperty
  a_hw_guard: assert property (p_hw_guard) else $error("write taken with guard pin low");
  property p_quad_pins; quad_pins_data |-> !(pause_active | pin_reset_active); endproperty
  a_quad_pins: assert property (p_quad_pins) else $error("pin function active in quad mode");
  property p_drive; (up_q == 2'h3 && $stable(drive_level)) |-> drive_percent == pct_w; endproperty
  a_drive: assert property (p_drive) else $error("drive strength decode wrong");
  property p_plain;
    ($past(rd_kind) == spc_pkg::SPC_RD_PLAIN && rd_kind == spc_pkg::SPC_RD_PLAIN) |-> rd_dummy_cycles == 4'h0;
  endproperty
  a_plain: assert property (p_plain) else $error("plain read has dummy cycles");
  property p_lock_keep;
    (up_q == 2'h3 && $past(up_q) == 2'h3) |-> ($past(status_reg_two[5:2]) & ~status_reg_two[5:2]) == 4'h0;
  endproperty
  a_lock_keep: assert property (p_lock_keep) else $error("lock bit cleared");
  c_accept: cover property (wrsr_accepted);
  c_reject: cover property (wrsr_rejected);
  c_quad: cover property (quad_pins_data);
endmodule
bind spc_status_protect spc_sp_checker u_chk (.clk_sys, .reset, .wrsr_valid, .rd_kind, .status_reg_one,
  .status_reg_two, .wrsr_accepted, .wrsr_rejected, .quad_pins_data, .pause_active, .pin_reset_active,
  .pin_write_guard_low, .drive_level, .drive_percent, .rd_dummy_cycles);

//--- tb/spc_host_model.sv
// Host controller model: sends opcode strobes and status writes.
// Assumes the block takes strobes at the rising edge of clk_sys.
`timescale 1ns/1ps
module spc_host_model (
  input  wire logic       clk_sys,
  output logic            cmd_valid,
  output logic [7:0]      cmd_opcode,
  output logic            wrsr_valid,
  output logic [7:0]      wrsr_s1,
  output logic [7:0]      wrsr_s2,
  output logic [7:0]      wrsr_s3,
  output logic [1:0]      wrsr_mask
);
  // Idle values at time zero
  initial begin
    cmd_valid = 1'b0;
    wrsr_valid = 1'b0;
    {cmd_opcode, wrsr_s1, wrsr_s2, wrsr_s3, wrsr_mask} = '0;
  end
  // Released buses show the inverse, so a stale value can never look right
  task automatic send_cmd(input logic [7:0] op);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_opcode <= op;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
  endtask
  // Callers send the enable first, or none to test a refused write; ordinary or volatile picks the copy
  task automatic send_wrsr(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input logic [1:0] m);
    @(posedge clk_sys);
    wrsr_valid <= 1'b1;
    {wrsr_s1, wrsr_s2, wrsr_s3, wrsr_mask} <= {a, b, c, m};
    @(posedge clk_sys);
    wrsr_valid <= 1'b0;
    {wrsr_s1, wrsr_s2, wrsr_s3, wrsr_mask} <= ~{a, b, c, m};
  endtask
endmodule

//--- tb/spc_status_protect_tb.sv
// Testbench of the status protection block with a host model in front.
// Assumes the verdict pulse one cycle after the write and images two cycles after.
`timescale 1ns/1ps
module spc_status_protect_tb;
  logic                 clk_sys = 1'b0, reset = 1'b1, power_up = 1'b0, soft_reset = 1'b0;
  logic                 busy_in = 1'b0, guard_pin_n = 1'b0, shared_pin_n = 1'b1, pe_check = 1'b0, pe_allowed;
  logic [5:0]           pe_block_lo = 6'h00, pe_block_hi = 6'h00;
  spc_pkg::spc_rdkind_e rd_kind = spc_pkg::SPC_RD_PLAIN;
  logic                 cmd_valid, wrsr_valid, wrsr_accepted, quad_pins_data, pause_active, pin_reset_active;
  logic                 fast_mode_bit;
  logic [7:0]           cmd_opcode, wrsr_s1, wrsr_s2, wrsr_s3, status_reg_one, status_reg_two, status_reg_three;
  logic [1:0]           wrsr_mask, drive_level;
  logic [6:0]           drive_percent;
  logic [3:0]           rd_mode_cycles, rd_dummy_cycles;
  logic [2:0]           security_locked_n;
  integer               fails = 0, n_tests = 0;
  always #12.5 clk_sys = ~clk_sys;
  spc_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode),
    .wrsr_valid(wrsr_valid), .wrsr_s1(wrsr_s1), .wrsr_s2(wrsr_s2), .wrsr_s3(wrsr_s3), .wrsr_mask(wrsr_mask));
  spc_status_protect u_dut (.clk_sys(clk_sys), .reset(reset), .power_up(power_up), .soft_reset(soft_reset),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .wrsr_valid(wrsr_valid), .wrsr_s1(wrsr_s1),
    .wrsr_s2(wrsr_s2), .wrsr_s3(wrsr_s3), .wrsr_mask(wrsr_mask), .wel_clear(1'b0), .busy_in(busy_in),
    .guard_pin_n(guard_pin_n), .shared_pin_n(shared_pin_n), .pe_block_lo(pe_block_lo),
    .pe_block_hi(pe_block_hi), .pe_check(pe_check), .rd_kind(rd_kind), .status_reg_one(status_reg_one),
    .status_reg_two(status_reg_two), .status_reg_three(status_reg_three), .wrsr_accepted(wrsr_accepted),
    .wrsr_rejected(), .pe_allowed(pe_allowed),
    .quad_pins_data(quad_pins_data), .pause_active(pause_active), .pin_reset_active(pin_reset_active),
    .pin_write_guard_low(), .drive_level(drive_level), .drive_percent(drive_percent),
    .fast_mode_bit(fast_mode_bit), .rd_mode_cycles(rd_mode_cycles), .rd_dummy_cycles(rd_dummy_cycles),
    .security_locked_n(security_locked_n));
  task automatic test_done();
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Optional enable, one status write, then the verdict one cycle later
  task automatic wr(input logic [7:0] op, a, b, c, input logic [1:0] m, input logic acc);
    if (op != 8'h00) u_host.send_cmd(op);
    u_host.send_wrsr(a, b, c, m);
    // The verdict pulse stands only in the cycle right after the sampling edge
    #1 check(wrsr_accepted, acc);
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse_rst(input logic pw);
    @(posedge clk_sys);
    {power_up, soft_reset} <= {pw, ~pw};
    @(posedge clk_sys);
    {power_up, soft_reset} <= 2'b00;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_legacy();
    logic [3:0] mode_x [7] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h2, 4'h2};
    logic [3:0] dum_x [7] = '{4'h0, 4'h8, 4'h8, 4'h8, 4'h0, 4'h4, 4'h2};
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_sys);
      rd_kind <= spc_pkg::spc_rdkind_e'(3'(k));
      repeat (2) @(posedge clk_sys);
      #1 check(rd_mode_cycles, mode_x[k]);
      check(rd_dummy_cycles, dum_x[k]);
    end
  endtask
  // Protection check of one block range; the answer pulse is looked at while it stands
  task automatic pe_try(input logic [5:0] blk, input logic exp);
    @(posedge clk_sys);
    pe_block_lo <= blk;
    pe_block_hi <= blk;
    pe_check    <= 1'b1;
    @(posedge clk_sys);
    pe_check    <= 1'b0;
    #1 check(pe_allowed, exp);
  endtask
  task automatic t_protect();
    wr(8'h50, 8'h04, 8'h00, 8'h40, 2'b01, 1'b1);
    pe_try(6'd31, 1'b0);
    pe_try(6'd30, 1'b1);
    pulse_rst(1'b0);
  endtask
  task automatic t_nv_and_guard();
    shared_pin_n <= 1'b0;
    wr(8'h06, 8'h00, 8'h0A, 8'h40, 2'b01, 1'b1);
    check(status_reg_two, 8'h0E);
    check({quad_pins_data, pause_active, security_locked_n}, 8'h16);
    wr(8'h00, 8'h00, 8'h0C, 8'h40, 2'b01, 1'b0);
    wr(8'h06, 8'h03, 8'h00, 8'h40, 2'b01, 1'b1);
    check({status_reg_one, status_reg_two}, {8'h00, 8'h0C});
    check({quad_pins_data, pause_active}, 2'b01);
    wr(8'h06, 8'h80, 8'h0C, 8'h40, 2'b01, 1'b1);
    wr(8'h06, 8'h00, 8'h0C, 8'h40, 2'b01, 1'b0);
    guard_pin_n <= 1'b1;
    wr(8'h06, 8'h00, 8'h0D, 8'h40, 2'b01, 1'b1);
    wr(8'h06, 8'h00, 8'h0C, 8'h40, 2'b01, 1'b0);
    pulse_rst(1'b0);
    check({status_reg_two[0], status_reg_one[7]}, 2'b00);
  endtask
  task automatic t_vol();
    logic [6:0] pct [4] = '{7'h32, 7'h19, 7'h4B, 7'h64};
    for (int d = 0; d < 4; d++) begin
      wr(8'h50, 8'h00, 8'h3C, {1'b1, 2'(d), 5'h15}, 2'b11, 1'b1);
      check(drive_percent, pct[d]);
    end
    check({security_locked_n, pin_reset_active, fast_mode_bit}, 5'h1B);
    rd_kind <= spc_pkg::SPC_RD_FAST;
    repeat (2) @(posedge clk_sys);
    #1 check(rd_dummy_cycles, 4'h5);
    pulse_rst(1'b0);
    check(status_reg_three, 8'h40);
  endtask
  task automatic t_suspend_otp();
    u_host.send_cmd(8'h75);
    busy_in <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 check({status_reg_two[7], status_reg_one[0]}, 2'b11);
    busy_in <= 1'b0;
    wr(8'h06, 8'h00, 8'h0C, 8'h40, 2'b01, 1'b1);
    check(status_reg_two[7], 1'b1);
    u_host.send_cmd(8'h7A);
    repeat (3) @(posedge clk_sys);
    #1 check(status_reg_two[7], 1'b0);
    wr(8'h06, 8'h80, 8'h0D, 8'h40, 2'b01, 1'b1);
    wr(8'h06, 8'h00, 8'h0C, 8'h40, 2'b01, 1'b0);
    pulse_rst(1'b1);
    wr(8'h06, 8'h00, 8'h0C, 8'h40, 2'b01, 1'b0);
  endtask
  // Main sequence; the watchdog ends a hung run as a failure
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check({status_reg_one, status_reg_two, status_reg_three}, {8'h00, 8'h04, 8'h40});
    check({fast_mode_bit, security_locked_n, drive_percent}, {1'b0, 3'b111, 7'h4B});
    t_legacy();
    t_nv_and_guard();
    t_vol();
    t_protect();
    t_suspend_otp();
    test_done();
  end
  initial begin
    #50us;
    fails++;
    test_done();
  end
endmodule
